/* File: status_mode_regs.svh */
`ifndef STATUS_MODE_REGS_SVH
`define STATUS_MODE_REGS_SVH
// processor status word field positions
`define SR_LIMIT_BIT 6
`define SR_MASK_LO 8
`define SR_MASK_HI 9
`define SR_SCALE_LO 10
`define SR_SCALE_HI 11
`define SR_TRACE_BIT 13
`define SR_LOOP_BIT 15
// implemented status bits; condition codes live in the alu, reserved bits read zero
`define SR_IMPL_MASK 16'haf40
`define SR_RSVD_MASK 16'h5080
// hardware reset value of the status word: both interrupt mask bits set
`define SR_HW_RESET 16'h0300
// operating mode word field positions
`define OMR_CM_LO 0
`define OMR_CM_HI 1
`define OMR_TROM_BIT 2
`define OMR_STOP_DLY 6
`define OMR_EXT_BUS 7
`define OMR_IMPL_MASK 24'h0000c7
`define OMR_RESET 24'h000000
// chip mode codes
`define CM_SINGLE 2'h0
`define CM_BOOT 2'h1
`define CM_EXPANDED 2'h2
// rounding bit positions
`define RND_NONE 5'h17
`define RND_DOWN 5'h18
`define RND_UP 5'h16
// table rom window in x and y data space
`define TROM_LO 16'h0100
`define TROM_HI 16'h01ff
// stop exit delays in t states, and t states per core clock
`define STOP_LONG_T 131072
`define STOP_SHORT_T 16
`define T_PER_CLK 1
`endif

/* File: status_mode_pkg.sv */
`default_nettype none
package status_mode_pkg;
   // control register instruction applied this cycle
   typedef enum logic [1:0] {
      OP_NONE,
      OP_MOVE,
      OP_AND,
      OP_OR
   } ctrl_op_t;
   // bootstrap sequencing
   typedef enum logic {
      BOOT_IDLE,
      BOOT_LOAD
   } boot_state_t;
   // stop exit counter sequencing
   typedef enum logic {
      STP_IDLE,
      STP_COUNT
   } stop_state_t;
   // whole state of the core block
   typedef struct packed {
      logic [15:0] sr;
      logic [23:0] operating_mode_word;
      logic trace_armed;
      boot_state_t boot;
      logic [3:0] wait_cnt;
      logic ext_prev;
      logic irq_admit;
      logic [23:0] readout;
      logic [4:0] round_pos;
      logic trace_exc;
      logic push;
      logic [15:0] push_word;
      logic boot_exec;
      logic rom_sel;
      logic pin_out;
      logic acc_wait;
   } core_state_t;
   // synchroniser stages
   typedef struct packed {
      logic [2:0] s1;
      logic [2:0] s2;
   } sync_state_t;
   // stop delay counter
   typedef struct packed {
      stop_state_t st;
      logic [17:0] cnt;
      logic busy;
      logic done;
   } stop_cnt_t;
endpackage
`default_nettype wire

/* File: pin_sync.sv */
`timescale 1ns/10ps
`default_nettype none
// two-stage synchroniser for the three pins that enter from outside
module pin_sync (
   input wire logic core_clk_in,
   input wire logic [2:0] pins_in,
   output logic [2:0] pins_out
);
   status_mode_pkg::sync_state_t st_r; // both stages
   status_mode_pkg::sync_state_t st_nxt; // next stages

   // first stage feeds only the second; no reset so straps flow during reset
   always_comb begin
      st_nxt = st_r;
      for (int i = 0; i < 3; i++) begin
         st_nxt.s1[i] = pins_in[i];
         st_nxt.s2[i] = st_r.s1[i];
      end
   end

   // register the stages
   always_ff @(posedge core_clk_in) begin
      st_r <= st_nxt;
   end

   assign pins_out = st_r.s2;
endmodule
`default_nettype wire

/* File: stop_delay.sv */
`timescale 1ns/10ps
`default_nettype none
`include "status_mode_regs.svh"
// counts the recovery delay after leaving the stop state
module stop_delay #(
   parameter int LONG_CYCLES = `STOP_LONG_T / `T_PER_CLK
) (
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic start_in,
   input wire logic short_sel_in,
   output logic busy_out,
   output logic done_out
);
   localparam int SHORT_CYCLES = `STOP_SHORT_T / `T_PER_CLK; // short delay in clocks
   status_mode_pkg::stop_cnt_t st_r; // counter state
   status_mode_pkg::stop_cnt_t st_nxt; // next counter state

   // load on exit request, count down, pulse done when the last cycle passes
   always_comb begin
      st_nxt = st_r;
      st_nxt.done = 1'b0;
      case (st_r.st)
         status_mode_pkg::STP_IDLE: begin
            if (start_in) begin
               st_nxt.st = status_mode_pkg::STP_COUNT;
               st_nxt.busy = 1'b1;
               // short delay only when the stop delay bit is one
               st_nxt.cnt = short_sel_in ? 18'(SHORT_CYCLES - 1) : 18'(LONG_CYCLES - 1);
            end
         end
         status_mode_pkg::STP_COUNT: begin
            if (st_r.cnt == 18'h00000) begin
               st_nxt.st = status_mode_pkg::STP_IDLE;
               st_nxt.busy = 1'b0;
               st_nxt.done = 1'b1;
            end else begin
               st_nxt.cnt = st_r.cnt - 18'h00001;
            end
         end
         default: begin
            st_nxt.st = status_mode_pkg::STP_IDLE;
         end
      endcase
      if (!rst_n_in) begin
         st_nxt = '0;
      end
   end

   // register the counter
   always_ff @(posedge core_clk_in) begin
      st_r <= st_nxt;
   end

   assign busy_out = st_r.busy;
   assign done_out = st_r.done;
endmodule
`default_nettype wire

/* File: status_mode_core.sv */
`timescale 1ns/10ps
`default_nettype none
`include "status_mode_regs.svh"
////////////////////////////////////////////////////////////////////////////////
// Function
// - overflow or limiting sets the limit bit
// - limit bit sticky until reset or clear
// - mask bits set the admitted interrupt level
// - hardware reset sets masks, software reset keeps
// - scale bits pick shift and rounding position
// - scaling only on accumulator bus readout
// - long interrupt and reset clear scale bits
// - trace bit at start raises trace exception
// - trace interrupt stacks set bit, then clears
// - status bits 7, 12, 14 read zero
// - loop end restores only the loop flag
// - long interrupt pushes word, clears loop flag
// - mode word 24 bits, changed by instructions
// - reset loads chip mode from pins
// - chip mode selects bus expansion mode
// - bootstrap loads ram, then mode two
// - rom variant turns mode one into zero
// - table rom enable maps 0100 to 01ff
// - stop exit waits long or short delay
// - mode bit 7 picks bus pin function
// - wait input extends access only when set
// - reserved status bits ignore writes, read zero
module status_mode_core #(
   parameter int STOP_LONG_CYCLES = `STOP_LONG_T / `T_PER_CLK,
   parameter bit ROM_VARIANT = 1'b0
) (
   input wire logic core_clk_in,
   input wire logic rst_n_in,
   input wire logic sw_reset_in,
   input wire logic mode_pin_high_in,
   input wire logic mode_pin_low_in,
   input wire logic [1:0] sr_op_in,
   input wire logic [15:0] sr_imm_in,
   input wire logic [1:0] omr_op_in,
   input wire logic [23:0] omr_imm_in,
   input wire logic overflow_set_in,
   input wire logic limit_event_in,
   input wire logic instr_start_in,
   input wire logic instr_done_in,
   input wire logic long_irq_in,
   input wire logic long_irq_trace_in,
   input wire logic rti_in,
   input wire logic loop_start_in,
   input wire logic loop_end_in,
   input wire logic [15:0] pulled_sr_in,
   input wire logic irq_req_in,
   input wire logic [1:0] irq_level_in,
   input wire logic [55:0] acc_in,
   input wire logic stop_exit_in,
   input wire logic boot_done_in,
   input wire logic [15:0] data_addr_in,
   input wire logic ext_access_in,
   input wire logic [3:0] bus_wait_control_reg_in,
   input wire logic bus_busy_in,
   input wire logic bus_request_in,
   output logic [15:0] status_word_out,
   output logic [23:0] mode_word_out,
   output logic irq_admit_out,
   output logic [23:0] acc_readout_out,
   output logic [4:0] round_pos_out,
   output logic trace_exc_out,
   output logic stack_push_out,
   output logic [15:0] stack_word_out,
   output logic stop_wait_out,
   output logic stop_resume_out,
   output logic boot_load_out,
   output logic boot_exec_zero_out,
   output logic table_rom_sel_out,
   output logic bus_grant_out,
   output logic access_wait_out
);
   ////////////////////////////////////////////////////////////////////////////////
   // declarations
   status_mode_pkg::core_state_t st_r; // registered state
   status_mode_pkg::core_state_t st_nxt; // next state
   logic [2:0] pin_sync_q; // synchronised {bus pin, mode high, mode low}
   logic mode_pin_high; // synced strap b
   logic mode_pin_low; // synced strap a
   logic bus_pin; // synced request or wait pin
   logic wait_input; // wait input when strobe mode is selected
   status_mode_pkg::ctrl_op_t sr_op; // decoded status op
   status_mode_pkg::ctrl_op_t omr_op; // decoded mode op
   logic [23:0] sr_applied; // status op result before the reserved bits drop

   ////////////////////////////////////////////////////////////////////////////////
   // helpers
   // applies a move, and-immediate or or-immediate to a control word
   function automatic logic [23:0] apply_op(input status_mode_pkg::ctrl_op_t op,
                                            input logic [23:0] cur,
                                            input logic [23:0] imm);
      logic [23:0] res;
      res = cur;
      case (op)
         status_mode_pkg::OP_MOVE: res = imm;
         status_mode_pkg::OP_AND: res = cur & imm;
         status_mode_pkg::OP_OR: res = cur | imm;
         default: res = cur;
      endcase
      return res;
   endfunction

   // rounding position for a scale code; reserved code rounds like no scaling
   function automatic logic [4:0] round_of(input logic [1:0] sc);
      logic [4:0] r;
      r = `RND_NONE;
      case (sc)
         2'h1: r = `RND_DOWN;
         2'h2: r = `RND_UP;
         default: r = `RND_NONE;
      endcase
      return r;
   endfunction

   // accumulator word driven to the data buses under the scale code
   function automatic logic [23:0] scale_of(input logic [1:0] sc, input logic [55:0] acc);
      logic [23:0] w;
      w = acc[47:24];
      case (sc)
         2'h1: w = acc[48:25];
         2'h2: w = acc[46:23];
         default: w = acc[47:24];
      endcase
      return w;
   endfunction

   // the rom variant has no bootstrap mode
   function automatic logic [1:0] legal_mode(input logic [1:0] m);
      logic [1:0] r;
      r = m;
      if (ROM_VARIANT && m == `CM_BOOT) begin
         r = `CM_SINGLE;
      end
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // pin synchronisers and stop delay
   pin_sync u_pin_sync (
      .core_clk_in(core_clk_in),
      .pins_in({bus_request_in, mode_pin_high_in, mode_pin_low_in}),
      .pins_out(pin_sync_q)
   );

   // short delay when the stop delay bit is one
   stop_delay #(
      .LONG_CYCLES(STOP_LONG_CYCLES)
   ) u_stop_delay (
      .core_clk_in(core_clk_in),
      .rst_n_in(rst_n_in),
      .start_in(stop_exit_in),
      .short_sel_in(st_r.operating_mode_word[`OMR_STOP_DLY]),
      .busy_out(stop_wait_out),
      .done_out(stop_resume_out)
   );

   assign mode_pin_low = pin_sync_q[0];
   assign mode_pin_high = pin_sync_q[1];
   assign bus_pin = pin_sync_q[2];
   assign wait_input = bus_pin & st_r.operating_mode_word[`OMR_EXT_BUS];
   assign sr_op = status_mode_pkg::ctrl_op_t'(sr_op_in);
   assign omr_op = status_mode_pkg::ctrl_op_t'(omr_op_in);
   // status word op on a zero-extended copy, cut back to 16 bits in the next state
   assign sr_applied = apply_op(sr_op, {8'h00, st_r.sr}, {8'h00, sr_imm_in});

   ////////////////////////////////////////////////////////////////////////////////
   // next state of the whole block
   always_comb begin
      st_nxt = st_r;
      st_nxt.trace_exc = 1'b0;
      st_nxt.push = 1'b0;
      st_nxt.boot_exec = 1'b0;
      // status word instructions; reserved bits dropped
      if (sr_op != status_mode_pkg::OP_NONE) begin
         st_nxt.sr = sr_applied[15:0] & `SR_IMPL_MASK;
      end
      // return from interrupt restores the whole word
      if (rti_in) begin
         st_nxt.sr = pulled_sr_in & `SR_IMPL_MASK;
      end
      // end of loop restores the loop flag only
      if (loop_end_in) begin
         st_nxt.sr[`SR_LOOP_BIT] = pulled_sr_in[`SR_LOOP_BIT];
      end
      // loop start stacks the word and marks the loop running
      if (loop_start_in) begin
         st_nxt.push = 1'b1;
         st_nxt.push_word = st_r.sr;
         st_nxt.sr[`SR_LOOP_BIT] = 1'b1;
      end
      // long interrupt: stack first, then clear loop flag and scaling
      if (long_irq_in) begin
         st_nxt.push = 1'b1;
         st_nxt.push_word = st_r.sr;
         st_nxt.sr[`SR_LOOP_BIT] = 1'b0;
         st_nxt.sr[`SR_SCALE_HI] = 1'b0;
         st_nxt.sr[`SR_SCALE_LO] = 1'b0;
         if (long_irq_trace_in) begin
            st_nxt.sr[`SR_TRACE_BIT] = 1'b0;
         end
      end
      // trace bit sampled as an instruction begins
      if (instr_start_in) begin
         st_nxt.trace_armed = st_r.sr[`SR_TRACE_BIT];
      end
      if (instr_done_in) begin
         st_nxt.trace_exc = st_r.trace_armed;
         st_nxt.trace_armed = 1'b0;
      end
      // software reset: clears mode bits except the interrupt masks
      if (sw_reset_in) begin
         st_nxt.sr = st_r.sr & {16{1'b1}} & 16'h0300;
         st_nxt.trace_armed = 1'b0;
      end
      // limit events win over any clear except hardware reset in the same cycle
      if (overflow_set_in || limit_event_in) begin
         st_nxt.sr[`SR_LIMIT_BIT] = 1'b1;
      end
      // mode word instructions; only five bits exist
      if (omr_op != status_mode_pkg::OP_NONE) begin
         st_nxt.operating_mode_word = apply_op(omr_op, st_r.operating_mode_word, omr_imm_in) & `OMR_IMPL_MASK;
         st_nxt.operating_mode_word[1:0] = legal_mode(st_nxt.operating_mode_word[1:0]);
      end
      // bootstrap: hold while ram loads, then switch to expanded mode
      case (st_r.boot)
         status_mode_pkg::BOOT_IDLE: begin
            st_nxt.boot = status_mode_pkg::BOOT_IDLE;
         end
         status_mode_pkg::BOOT_LOAD: begin
            if (boot_done_in) begin
               st_nxt.boot = status_mode_pkg::BOOT_IDLE;
               st_nxt.operating_mode_word[1:0] = `CM_EXPANDED;
               st_nxt.boot_exec = 1'b1;
            end
         end
         default: begin
            st_nxt.boot = status_mode_pkg::BOOT_IDLE;
         end
      endcase
      // hardware reset: masks set, other fields clear, straps loaded
      if (!rst_n_in) begin
         st_nxt = '0;
         st_nxt.sr = `SR_HW_RESET;
         st_nxt.operating_mode_word = `OMR_RESET;
         st_nxt.operating_mode_word[1:0] = legal_mode({mode_pin_high, mode_pin_low});
         if (legal_mode({mode_pin_high, mode_pin_low}) == `CM_BOOT) begin
            st_nxt.boot = status_mode_pkg::BOOT_LOAD;
         end
      end
      // interrupt admission: level must reach the mask value
      st_nxt.irq_admit = rst_n_in && irq_req_in
                         && (irq_level_in >= st_nxt.sr[`SR_MASK_HI:`SR_MASK_LO]);
      // readout and rounding follow the scale bits
      st_nxt.readout = scale_of(st_nxt.sr[`SR_SCALE_HI:`SR_SCALE_LO], acc_in);
      st_nxt.round_pos = round_of(st_nxt.sr[`SR_SCALE_HI:`SR_SCALE_LO]);
      // table rom window decode
      st_nxt.rom_sel = st_nxt.operating_mode_word[`OMR_TROM_BIT]
                       && data_addr_in >= `TROM_LO && data_addr_in <= `TROM_HI;
      // external access wait states from the bus wait control count
      st_nxt.ext_prev = ext_access_in;
      if (ext_access_in && !st_r.ext_prev) begin
         st_nxt.wait_cnt = bus_wait_control_reg_in;
      end else if (ext_access_in && st_r.wait_cnt != 4'h0) begin
         st_nxt.wait_cnt = st_r.wait_cnt - 4'h1;
      end
      // wait input adds wait states only in strobe mode
      st_nxt.acc_wait = ext_access_in
                        && (st_nxt.wait_cnt != 4'h0 || wait_input);
      // shared pin: grant in request mode, strobe in strobe mode
      if (st_nxt.operating_mode_word[`OMR_EXT_BUS]) begin
         st_nxt.pin_out = ext_access_in;
      end else begin
         st_nxt.pin_out = bus_pin && !bus_busy_in;
      end
      if (!rst_n_in) begin
         st_nxt.wait_cnt = 4'h0;
         st_nxt.ext_prev = 1'b0;
         st_nxt.acc_wait = 1'b0;
         st_nxt.pin_out = 1'b0;
         st_nxt.rom_sel = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // state register
   always_ff @(posedge core_clk_in) begin
      st_r <= st_nxt;
   end

   // outputs come straight from the state register
   assign status_word_out = st_r.sr;
   assign mode_word_out = st_r.operating_mode_word;
   assign irq_admit_out = st_r.irq_admit;
   assign acc_readout_out = st_r.readout;
   assign round_pos_out = st_r.round_pos;
   assign trace_exc_out = st_r.trace_exc;
   assign stack_push_out = st_r.push;
   assign stack_word_out = st_r.push_word;
   assign boot_load_out = (st_r.boot == status_mode_pkg::BOOT_LOAD);
   assign boot_exec_zero_out = st_r.boot_exec;
   assign table_rom_sel_out = st_r.rom_sel;
   assign bus_grant_out = st_r.pin_out;
   assign access_wait_out = st_r.acc_wait;

   ////////////////////////////////////////////////////////////////////////////////
   // assertions
   limit_set_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (overflow_set_in || limit_event_in) |=> status_word_out[`SR_LIMIT_BIT])
      else $error("limit bit not set after overflow or limiting");

   limit_sticky_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (sr_op_in == 2'h0 && !rti_in && !sw_reset_in && status_word_out[`SR_LIMIT_BIT])
      |=> status_word_out[`SR_LIMIT_BIT])
      else $error("limit bit dropped without a clear");

   irq_mask_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      irq_admit_out |-> $past(irq_req_in) && $past(irq_level_in) >= status_word_out[9:8])
      else $error("interrupt admitted below the mask level");

   reset_mask_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      $rose(rst_n_in) |-> status_word_out == `SR_HW_RESET && !stop_wait_out)
      else $error("status word wrong after hardware reset");

   sw_reset_keep_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (sw_reset_in && sr_op_in == 2'h0 && !rti_in)
      |=> status_word_out[9:8] == $past(status_word_out[9:8]) && !status_word_out[11])
      else $error("software reset disturbed the interrupt masks");

   round_pos_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      status_word_out[11:10] == 2'h1 |-> round_pos_out == `RND_DOWN)
      else $error("rounding position does not follow scale down");

   round_rsvd_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      status_word_out[11:10] == 2'h3 |-> round_pos_out == `RND_NONE)
      else $error("reserved scale code does not round at bit 23");

   irq_entry_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (long_irq_in && !rti_in && !loop_start_in && !sw_reset_in && sr_op_in == 2'h0)
      |=> stack_push_out && stack_word_out == $past(status_word_out)
      && !status_word_out[`SR_LOOP_BIT] && status_word_out[11:10] == 2'h0)
      else $error("long interrupt entry did not stack and clear");

   trace_stack_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (long_irq_in && long_irq_trace_in && status_word_out[`SR_TRACE_BIT] && sr_op_in == 2'h0
      && !rti_in) |=> stack_word_out[`SR_TRACE_BIT] && !status_word_out[`SR_TRACE_BIT])
      else $error("trace interrupt did not stack the set trace bit");

   trace_exc_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      trace_exc_out |-> $past(instr_done_in))
      else $error("trace exception without a completed instruction");

   rsvd_zero_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (status_word_out & `SR_RSVD_MASK) == 16'h0000
      && (mode_word_out & ~`OMR_IMPL_MASK) == 24'h000000)
      else $error("reserved bit reads as one");

   loop_end_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      (loop_end_in && !rti_in && !loop_start_in && !long_irq_in && !sw_reset_in
      && sr_op_in == 2'h0) |=> status_word_out[`SR_LOOP_BIT] == $past(pulled_sr_in[15])
      && status_word_out[14:0] == ($past(status_word_out[14:0])
      | (15'(1 << `SR_LIMIT_BIT) & status_word_out[14:0])))
      else $error("loop end restored more than the loop flag");

   stop_short_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      $rose(stop_wait_out) && $past(mode_word_out[`OMR_STOP_DLY]) |-> ##16 stop_resume_out)
      else $error("short stop delay is not 16 cycles");

   rom_variant_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      ROM_VARIANT |-> mode_word_out[1:0] != `CM_BOOT)
      else $error("rom variant entered bootstrap mode");

   boot_exit_a: assert property (@(posedge core_clk_in) disable iff (!rst_n_in)
      boot_exec_zero_out |-> mode_word_out[1:0] == `CM_EXPANDED && !boot_load_out)
      else $error("bootstrap did not switch to expanded mode");

   trace_cov: cover property (@(posedge core_clk_in) disable iff (!rst_n_in)
      trace_exc_out ##[1:20] stack_push_out);
   stop_cov: cover property (@(posedge core_clk_in) disable iff (!rst_n_in)
      $rose(stop_wait_out) ##[1:40] stop_resume_out);
   boot_cov: cover property (@(posedge core_clk_in) disable iff (!rst_n_in)
      boot_load_out ##[1:50] boot_exec_zero_out);
   wait_cov: cover property (@(posedge core_clk_in) disable iff (!rst_n_in)
      mode_word_out[`OMR_EXT_BUS] && access_wait_out);
endmodule
`default_nettype wire

/* File: ext_master.sv */
`timescale 1ns/10ps
`default_nettype none
// far side: an outside bus master that asks for the bus and waits for grant
module ext_master (
   input wire logic clk_in,
   input wire logic want_in,
   input wire logic grant_in,
   output logic req_out,
   output logic owns_out
);
   // request follows demand; the bus is driven only once granted
   always_ff @(posedge clk_in) begin
      req_out <= want_in;
      owns_out <= want_in & req_out & grant_in;
   end
endmodule
`default_nettype wire

/* File: status_and_mode_registers_bench.sv */
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
$display("wrong value at %0t: %h", $time, a); end end
module status_and_mode_registers_bench;
   logic clk, rst_n, irq, busy, ext, want, req, owns;
   logic [1:0] sop, oop, lvl;
   logic [11:0] ev;
   logic [23:0] imm, mw;
   logic [15:0] addr, sw, skw, pul;
   logic [4:0] rp;
   logic ia, rd, te, sp, wt, gr, aw, mph, mpl, rs, bl, bx;
   logic [3:0] bus_wait_control_reg = 4'h2;
   logic [23:0] ar;
   logic [55:0] acc = 56'h00123456800000;
   logic [28:0] rdx [4] = '{{24'h123456, 5'h17}, {24'h091a2b, 5'h18}, {24'h2468ad, 5'h16},
      {24'h123456, 5'h17}};
   int fails, n_compared, n;
   logic [15:0] ta [4] = '{16'h00ff, 16'h0100, 16'h01ff, 16'h0200};
   status_mode_core #(.STOP_LONG_CYCLES(64)) dut (
      .core_clk_in(clk), .rst_n_in(rst_n), .sw_reset_in(ev[11]),
      .mode_pin_high_in(mph), .mode_pin_low_in(mpl),
      .sr_op_in(sop), .sr_imm_in(imm[15:0]), .omr_op_in(oop), .omr_imm_in(imm),
      .overflow_set_in(ev[0]), .limit_event_in(ev[1]), .instr_start_in(ev[2]),
      .instr_done_in(ev[3]), .long_irq_in(ev[4]), .long_irq_trace_in(ev[5]),
      .rti_in(ev[6]), .loop_start_in(ev[7]), .loop_end_in(ev[8]),
      .pulled_sr_in(pul), .irq_req_in(irq), .irq_level_in(lvl),
      .acc_in(acc), .stop_exit_in(ev[9]), .boot_done_in(ev[10]),
      .data_addr_in(addr), .ext_access_in(ext), .bus_wait_control_reg_in(bus_wait_control_reg),
      .bus_busy_in(busy), .bus_request_in(req), .status_word_out(sw),
      .mode_word_out(mw), .irq_admit_out(ia), .acc_readout_out(ar),
      .round_pos_out(rp), .trace_exc_out(te), .stack_push_out(sp),
      .stack_word_out(skw), .stop_wait_out(wt), .stop_resume_out(rs),
      .boot_load_out(bl), .boot_exec_zero_out(bx), .table_rom_sel_out(rd),
      .bus_grant_out(gr), .access_wait_out(aw));
   ext_master far (.clk_in(clk), .want_in(want), .grant_in(gr), .req_out(req),
      .owns_out(owns));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   // one register instruction, taken at the following edge
   task op(input [1:0] s, input [1:0] o, input [23:0] d);
      @(posedge clk) begin
         sop <= s;
         oop <= o;
         imm <= d;
      end
      @(posedge clk) begin
         sop <= 2'h0;
         oop <= 2'h0;
      end
      @(negedge clk);
   endtask
   // one-cycle event pulses
   task pls(input [11:0] m);
      @(posedge clk) ev <= m;
      @(posedge clk) ev <= 12'h000;
      @(negedge clk);
   endtask
   task tend(input int t);
      $display("test %0d done", t);
   endtask
   task complete_run;
      $display("compared %0d, wrong %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      {rst_n, irq, busy, ext, want, sop, oop, lvl, ev, imm, addr} = '0;
      {mph, mpl, pul} = 18'h27fff;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      `CHK(sw, 16'h0300)
      `CHK(mw, 24'h000002)
      op(2'h3, 2'h0, 24'h00ffff);
      `CHK(sw, 16'haf40)
      `CHK(rp, 5'h17)
      @(posedge clk) {irq, lvl} <= 3'h6;
      repeat (2) @(negedge clk);
      `CHK(ia, 1'b0)
      @(posedge clk) lvl <= 2'h3;
      repeat (2) @(negedge clk);
      `CHK(ia, 1'b1)
      tend(1);
      pls(12'h010);
      `CHK({sp, skw, sw}, {1'b1, 16'haf40, 16'h2340})
      pls(12'h800);
      `CHK(sw, 16'h0300)
      pls(12'h001);
      `CHK(sw, 16'h0340)
      op(2'h2, 2'h0, 24'h00ffbf);
      `CHK(sw, 16'h0300)
      tend(2);
      op(2'h3, 2'h0, 24'h002000);
      pls(12'h004);
      pls(12'h008);
      `CHK(te, 1'b1)
      pls(12'h030);
      `CHK({skw, sw}, {16'h2300, 16'h0300})
      pls(12'h080);
      `CHK(sw, 16'h8300)
      pls(12'h100);
      `CHK(sw, 16'h0300)
      pls(12'h040);
      `CHK(sw, 16'h2f40)
      tend(3);
      op(2'h0, 2'h1, 24'h000044);
      `CHK(mw, 24'h000044)
      for (int i = 0; i < 4; i++) begin
         @(posedge clk) addr <= ta[i];
         repeat (2) @(negedge clk);
         `CHK(rd, i == 1 || i == 2)
      end
      for (int k = 0; k < 2; k++) begin
         op(2'h0, 2'h1, k ? 24'h000000 : 24'h000040);
         pls(12'h200);
         n = 0;
         while (wt === 1'b1 && n < 99) begin
            n++;
            @(negedge clk);
         end
         `CHK(n, k ? 64 : 16)
         `CHK(rs, 1'b1)
      end
      for (int j = 0; j < 4; j++) begin
         op(2'h1, 2'h0, 24'(j << 10));
         `CHK({ar, rp}, rdx[j])
      end
      tend(4);
      @(posedge clk) want <= 1'b1;
      repeat (6) @(negedge clk);
      `CHK({gr, owns}, 2'h3)
      op(2'h0, 2'h1, 24'h000080);
      @(posedge clk) ext <= 1'b1;
      repeat (4) @(negedge clk);
      `CHK({gr, aw}, 2'h3)
      @(posedge clk) want <= 1'b0;
      repeat (5) @(negedge clk);
      `CHK(aw, 1'b0)
      tend(5);
      @(posedge clk) {rst_n, mph, mpl} <= 3'h1;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      @(negedge clk);
      `CHK({bl, mw}, {1'b1, 24'h000001})
      pls(12'h400);
      `CHK({bl, bx, aw, mw}, {3'h3, 24'h000002})
      tend(6);
      complete_run;
   end
   initial begin
      #50000;
      fails++;
      complete_run;
   end
endmodule
`default_nettype wire
